// ==== hdl/pmd_pkg.sv ====
// Shared constants and carriers for the program memory mode decoder.
// Assumes a 16-bit program space and an 8-bit data memory bus beside it.
package pmd_pkg;

	// Address and word widths
	localparam int PMD_PC_W = 16;
	localparam int PMD_WORD_W = 16;
	localparam int PMD_DADDR_W = 16;
	localparam int PMD_DATA_W = 8;

	// Reset and interrupt vectors, index 0..3 = pin, timer, timer clock pin, peripheral
	localparam logic [15:0] PMD_RESET_VEC = 16'h0000;
	localparam logic [3:0][15:0] PMD_IRQ_VEC = {16'h0020, 16'h0018, 16'h0010, 16'h0008};

	// Configuration strap codes; erased cells read as ones
	localparam logic [1:0] PMD_MODE_PROT = 2'h0;
	localparam logic [1:0] PMD_MODE_EXT = 2'h1;
	localparam logic [1:0] PMD_MODE_MCU = 2'h2;
	localparam logic [1:0] PMD_MODE_MPU = 2'h3;

	// Special areas at the top of the program space
	localparam logic [15:0] PMD_CFG_LO = 16'hFE00;
	localparam logic [15:0] PMD_TEST_LO = 16'hFE10;
	localparam logic [15:0] PMD_BOOT_LO = 16'hFF60;

	// Default on-chip size in words and the filler returned past it
	localparam int PMD_ONCHIP_WORDS = 2048;
	localparam logic [15:0] PMD_UNDEF_WORD = 16'hFFFF;

	typedef enum logic [1:0] {PMD_AREA_USER, PMD_AREA_CFG, PMD_AREA_TEST, PMD_AREA_BOOT} pmd_area_e;

	// Data memory access, carried on its own bus
	typedef struct packed {
		logic req;
		logic we;
		logic [15:0] addr;
		logic [7:0] wdata;
	} pmd_dbus_s;

	// Whole state of the decoder top
	typedef struct packed {
		logic taken;
		logic [1:0] mode;
		logic protect;
		logic [15:0] pc;
		logic s1_valid;
		logic s1_ext;
		logic s1_undef;
		logic [15:0] s1_addr;
		logic valid;
		logic src_ext;
		logic [15:0] word;
		logic ext_rd;
		logic [15:0] ext_addr;
		pmd_dbus_s dbus;
		logic prog_ack;
		logic prog_denied;
		logic [15:0] prog_rdata;
	} pmd_state_s;

endpackage : pmd_pkg

// ==== hdl/pmd_prog_store.sv ====
// On-chip program memory held in flip-flops, one write port and two read ports.
// Assumes the caller checks protection and range before writing.
`timescale 1ns/1ps
module pmd_prog_store #(
	parameter int DEPTH = pmd_pkg::PMD_ONCHIP_WORDS,
	parameter int AW = $clog2(DEPTH)
) (
	// Clock
	input wire logic ref_clk,
	// Write port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [15:0] wr_data,
	// Read ports, combinational
	input wire logic [AW-1:0] rd_addr_a,
	output logic [15:0] rd_data_a,
	input wire logic [AW-1:0] rd_addr_b,
	output logic [15:0] rd_data_b
);
	logic [DEPTH-1:0][15:0] mem_ff;

	// One word per entry; no reset, contents are loaded by the programmer port
	for (genvar gi = 0; gi < DEPTH; gi++) begin : g_word
		always_ff @(posedge ref_clk) begin
			if (wr_en && (wr_addr == AW'(gi))) begin
				mem_ff[gi] <= wr_data;
			end
		end
	end

	// Fetch and programmer reads
	assign rd_data_a = mem_ff[rd_addr_a];
	assign rd_data_b = mem_ff[rd_addr_b];

endmodule : pmd_prog_store

// ==== hdl/pmd_area_guard.sv ====
// Classifies a programmer address and grants access by memory mode.
// Assumes mode is already captured from the straps.
`timescale 1ns/1ps
module pmd_area_guard (
	// Request
	input wire logic [1:0] mode,
	input wire logic [15:0] addr,
	input wire logic is_write,
	input wire logic onchip,
	// Verdict
	output pmd_pkg::pmd_area_e area,
	output logic granted
);
	// Top areas first, user space below them
	always_comb begin
		if (addr >= pmd_pkg::PMD_BOOT_LO) begin
			area = pmd_pkg::PMD_AREA_BOOT;
		end else if (addr >= pmd_pkg::PMD_TEST_LO) begin
			area = pmd_pkg::PMD_AREA_TEST;
		end else if (addr >= pmd_pkg::PMD_CFG_LO) begin
			area = pmd_pkg::PMD_AREA_CFG;
		end else begin
			area = pmd_pkg::PMD_AREA_USER;
		end
	end

	// Each mode has its own access level; protected mode locks everything but reads
	// of the configuration words, so a protected part can still be identified
	always_comb begin
		unique case (area)
			pmd_pkg::PMD_AREA_USER: granted = onchip && (mode == pmd_pkg::PMD_MODE_MCU
				|| mode == pmd_pkg::PMD_MODE_EXT);
			pmd_pkg::PMD_AREA_CFG: granted = !is_write || (mode != pmd_pkg::PMD_MODE_PROT);
			pmd_pkg::PMD_AREA_TEST: granted = (mode == pmd_pkg::PMD_MODE_MCU)
				|| (mode == pmd_pkg::PMD_MODE_MPU);
			pmd_pkg::PMD_AREA_BOOT: granted = (mode == pmd_pkg::PMD_MODE_MCU);
		endcase
	end

endmodule : pmd_area_guard

// ==== hdl/pmd_decoder.sv ====
// Program memory mode decoder: program counter, vectors, fetch routing between
// on-chip and external program memory, code protection, separate data bus.
// Assumes the core issues one fetch at a time and external memory answers in
// the cycle its address is driven.
`timescale 1ns/1ps

// Overview of operation
// - Program and data accesses use separate buses and may occur in one cycle.
// - A 16-bit program counter addresses 64K words of 16 bits.
// - After reset, fetching starts at address zero.
// - Vectors: pin 0008h, timer 0010h, timer clock pin 0018h, peripheral 0020h.
// - Four memory modes chosen by two configuration bits.
// - Microcontroller and protected modes fetch on-chip only, external bus idle.
// - Internal-only fetch past on-chip memory returns an undefined word.
// - Protected microcontroller mode also turns on code protection.
// - Extended mode routes each fetch by address across the 64K space.
// - Microprocessor mode fetches everything externally, ignoring on-chip memory.
// - Unprogrammed configuration bits select microprocessor mode.
// - Each mode has its own access to configuration, test and boot areas.
module pmd_decoder #(
	parameter int ONCHIP_WORDS = pmd_pkg::PMD_ONCHIP_WORDS
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Configuration straps
	input wire logic [1:0] cfg_mode,
	// Core program counter control
	input wire logic fetch_req,
	input wire logic vec_req,
	input wire logic [1:0] vec_sel,
	input wire logic pc_load,
	input wire logic [15:0] pc_target,
	// Fetch answer to the core
	output logic fetch_ready,
	output logic fetch_valid,
	output logic fetch_src_ext,
	output logic [15:0] fetch_word,
	output logic [15:0] pc,
	// External program memory bus
	output logic ext_rd,
	output logic [15:0] ext_addr,
	input wire logic [15:0] ext_rdata,
	// Data memory bus
	input wire pmd_pkg::pmd_dbus_s dbus_in,
	output pmd_pkg::pmd_dbus_s dbus_out,
	// Programmer port
	input wire logic prog_req,
	input wire logic prog_we,
	input wire logic [15:0] prog_addr,
	input wire logic [15:0] prog_wdata,
	output logic prog_ack,
	output logic prog_denied,
	output logic [15:0] prog_rdata,
	// Mode status
	output logic [1:0] mode,
	output logic code_protect
);
	localparam int AW = $clog2(ONCHIP_WORDS);
	localparam logic [16:0] BOUNDARY = 17'(ONCHIP_WORDS);

	pmd_pkg::pmd_state_s cur_ff;
	pmd_pkg::pmd_state_s nxt_cur;
	logic [15:0] store_rd_a;
	logic [15:0] store_rd_b;
	logic fetch_onchip;
	logic prog_onchip;
	logic prog_granted;
	logic store_we;
	pmd_pkg::pmd_area_e prog_area;

	// Boundary compare against the parameter, not a fixed address
	assign fetch_onchip = {1'b0, cur_ff.pc} < BOUNDARY;
	assign prog_onchip = {1'b0, prog_addr} < BOUNDARY;
	assign store_we = prog_req && prog_we && prog_granted && prog_area == pmd_pkg::PMD_AREA_USER;

	pmd_prog_store #(
		.DEPTH(ONCHIP_WORDS),
		.AW(AW)
	) u_store (
		.ref_clk(ref_clk),
		.wr_en(store_we),
		.wr_addr(prog_addr[AW-1:0]),
		.wr_data(prog_wdata),
		.rd_addr_a(cur_ff.s1_addr[AW-1:0]),
		.rd_data_a(store_rd_a),
		.rd_addr_b(prog_addr[AW-1:0]),
		.rd_data_b(store_rd_b)
	);

	pmd_area_guard u_guard (
		.mode(cur_ff.mode),
		.addr(prog_addr),
		.is_write(prog_we),
		.onchip(prog_onchip),
		.area(prog_area),
		.granted(prog_granted)
	);

	// Next state: straps, program counter, two-stage fetch, data and programmer ports
	always_comb begin
		nxt_cur = cur_ff;
		// Straps are taken once, one cycle after reset; fetches wait for it so
		// no fetch is ever routed under a mode that is about to change
		if (!cur_ff.taken) begin
			nxt_cur.taken = 1'b1;
			nxt_cur.mode = cfg_mode;
		end
		nxt_cur.protect = (cur_ff.mode == pmd_pkg::PMD_MODE_PROT) && cur_ff.taken;

		// Program counter: vector beats load beats increment; wraps at 64K
		if (vec_req) begin
			nxt_cur.pc = pmd_pkg::PMD_IRQ_VEC[vec_sel];
		end else if (pc_load) begin
			nxt_cur.pc = pc_target;
		end else if (fetch_req && cur_ff.taken) begin
			nxt_cur.pc = cur_ff.pc + 16'h0001;
		end

		// Stage 1: route the fetch by mode and address
		nxt_cur.s1_valid = fetch_req && cur_ff.taken;
		nxt_cur.s1_addr = cur_ff.pc;
		unique case (cur_ff.mode)
			pmd_pkg::PMD_MODE_MPU: begin
				nxt_cur.s1_ext = 1'b1;
				nxt_cur.s1_undef = 1'b0;
			end
			pmd_pkg::PMD_MODE_EXT: begin
				nxt_cur.s1_ext = !fetch_onchip;
				nxt_cur.s1_undef = 1'b0;
			end
			pmd_pkg::PMD_MODE_MCU, pmd_pkg::PMD_MODE_PROT: begin
				nxt_cur.s1_ext = 1'b0;
				nxt_cur.s1_undef = !fetch_onchip;
			end
		endcase
		// External strobe stands only for external fetches
		nxt_cur.ext_rd = nxt_cur.s1_valid && nxt_cur.s1_ext;
		nxt_cur.ext_addr = nxt_cur.ext_rd ? cur_ff.pc : cur_ff.ext_addr;

		// Stage 2: capture the word from whichever memory answered
		nxt_cur.valid = cur_ff.s1_valid;
		nxt_cur.src_ext = cur_ff.s1_ext;
		if (cur_ff.s1_valid) begin
			if (cur_ff.s1_ext) begin
				nxt_cur.word = ext_rdata;
			end else if (cur_ff.s1_undef) begin
				nxt_cur.word = pmd_pkg::PMD_UNDEF_WORD;
			end else begin
				nxt_cur.word = store_rd_a;
			end
		end

		// Data bus runs beside the fetch path, never waiting on it
		nxt_cur.dbus = dbus_in;

		// Programmer port: one-cycle answer, denied requests read as zero
		nxt_cur.prog_ack = prog_req && cur_ff.taken;
		nxt_cur.prog_denied = prog_req && cur_ff.taken && !prog_granted;
		if (prog_req && !prog_we && prog_granted && prog_area == pmd_pkg::PMD_AREA_USER) begin
			nxt_cur.prog_rdata = store_rd_b;
		end else if (prog_req && !prog_we && prog_granted) begin
			nxt_cur.prog_rdata = pmd_pkg::PMD_UNDEF_WORD;
		end else if (prog_req) begin
			nxt_cur.prog_rdata = 16'h0000;
		end
	end

	// State register; unprogrammed mode until the straps are taken
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			cur_ff <= '0;
			cur_ff.mode <= pmd_pkg::PMD_MODE_MPU;
			cur_ff.pc <= pmd_pkg::PMD_RESET_VEC;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// Every output is a field of the state register
	assign fetch_ready = cur_ff.taken;
	assign fetch_valid = cur_ff.valid;
	assign fetch_src_ext = cur_ff.src_ext;
	assign fetch_word = cur_ff.word;
	assign pc = cur_ff.pc;
	assign ext_rd = cur_ff.ext_rd;
	assign ext_addr = cur_ff.ext_addr;
	assign dbus_out = cur_ff.dbus;
	assign prog_ack = cur_ff.prog_ack;
	assign prog_denied = cur_ff.prog_denied;
	assign prog_rdata = cur_ff.prog_rdata;
	assign mode = cur_ff.mode;
	assign code_protect = cur_ff.protect;

	// Checks
	logic internal_mode;
	assign internal_mode = (cur_ff.mode == pmd_pkg::PMD_MODE_MCU)
		|| (cur_ff.mode == pmd_pkg::PMD_MODE_PROT);

	dbus_sep_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		dbus_in.req && fetch_req |=> dbus_out.req && dbus_out.addr == $past(dbus_in.addr))
		else $error("data access delayed by fetch");

	pc_inc_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		fetch_req && fetch_ready && !vec_req && !pc_load |=> pc == $past(pc) + 16'h0001)
		else $error("program counter did not advance");

	reset_pc_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!$past(rst_b) |-> pc == 16'h0000 && !fetch_ready)
		else $error("fetch does not start at zero");

	vec_pc_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		vec_req && vec_sel == 2'h3 |=> pc == 16'h0020)
		else $error("peripheral vector wrong");

	mode_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		fetch_ready && $past(fetch_ready) |-> $stable(mode))
		else $error("mode changed after capture");

	no_ext_int_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		internal_mode |=> !ext_rd)
		else $error("external bus driven in internal mode");

	undef_word_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		internal_mode && fetch_req && fetch_ready && !fetch_onchip
		|-> ##2 fetch_valid && fetch_word == 16'hFFFF && !fetch_src_ext)
		else $error("fetch past on-chip memory not undefined");

	protect_on_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		fetch_ready && mode == pmd_pkg::PMD_MODE_PROT |=> code_protect)
		else $error("protection not on in protected mode");

	ext_route_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		mode == pmd_pkg::PMD_MODE_EXT && fetch_req && fetch_ready
		|=> ext_rd == !($past(pc) < 16'(ONCHIP_WORDS)) ##1 fetch_src_ext == $past(ext_rd))
		else $error("extended mode routed wrong");

	mpu_all_ext_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		mode == pmd_pkg::PMD_MODE_MPU && fetch_req && fetch_ready
		|=> ext_rd && ext_addr == $past(pc))
		else $error("microprocessor fetch not external");

	unprog_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!fetch_ready && cfg_mode == 2'h3 |=> mode == 2'h3 && fetch_ready)
		else $error("erased straps not microprocessor");

	prot_lock_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		code_protect && prog_req && prog_addr < 16'hFE00 |=> prog_denied && prog_rdata == 16'h0000)
		else $error("protected memory reachable");

	vec_all_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		vec_req |=> pc == pmd_pkg::PMD_IRQ_VEC[$past(vec_sel)])
		else $error("vector address wrong");

	load_pc_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		pc_load && !vec_req |=> pc == $past(pc_target))
		else $error("jump target not loaded");

	pc_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		fetch_ready && !fetch_req && !vec_req && !pc_load |=> $stable(pc))
		else $error("program counter moved while idle");

	fetch_lat_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		fetch_req && fetch_ready |-> ##2 fetch_valid)
		else $error("fetch answer late");

	int_src_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		internal_mode && fetch_req && fetch_ready |-> ##2 fetch_valid && !fetch_src_ext)
		else $error("internal mode word not on-chip");

	ext_onchip_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		mode == pmd_pkg::PMD_MODE_EXT && fetch_req && fetch_ready && fetch_onchip
		|-> ##2 fetch_valid && !fetch_src_ext && fetch_word == $past(store_rd_a))
		else $error("extended mode on-chip word wrong");

	mpu_data_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		mode == pmd_pkg::PMD_MODE_MPU && fetch_req && fetch_ready
		|-> ##2 fetch_valid && fetch_src_ext && fetch_word == $past(ext_rdata))
		else $error("microprocessor word not from external bus");

	protect_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		fetch_ready && mode != pmd_pkg::PMD_MODE_PROT |=> !code_protect)
		else $error("protection on outside protected mode");

	prog_ack_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		prog_req && fetch_ready |=> prog_ack)
		else $error("programmer request not answered");

	boot_lock_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		prog_req && fetch_ready && prog_addr >= pmd_pkg::PMD_BOOT_LO
		&& mode != pmd_pkg::PMD_MODE_MCU |=> prog_denied)
		else $error("boot area reachable outside microcontroller mode");

	dbus_copy_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		fetch_req |=> dbus_out == $past(dbus_in))
		else $error("data bus word altered beside fetch");

	ext_fetch_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
		ext_rd ##1 fetch_valid && fetch_src_ext);
	int_fetch_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
		fetch_valid && !fetch_src_ext && mode == pmd_pkg::PMD_MODE_EXT);
	vec_fetch_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
		vec_req ##1 fetch_req);
	undef_fetch_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
		fetch_valid && !fetch_src_ext && fetch_word == pmd_pkg::PMD_UNDEF_WORD);
	prot_deny_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
		code_protect && prog_denied);

endmodule : pmd_decoder

// ==== testbench/pmd_ext_mem.sv ====
// External program memory model facing the decoder's read strobe.
// Assumes the word is sampled at the edge that ends the strobe cycle.
`timescale 1ns/1ps
module pmd_ext_mem #(
	parameter logic [15:0] KEY = 16'h5A3C
) (
	// Bus from the decoder
	input wire logic ref_clk,
	input wire logic ext_rd,
	input wire logic [15:0] ext_addr,
	// Answer
	output logic [15:0] ext_rdata
);
	logic [15:0] last_ff = 16'h0000;

	// Remember the last word so idle cycles can show its inverse
	always @(posedge ref_clk) begin
		last_ff <= ext_rdata;
	end

	// Unselected cycles toggle every cycle, so a stale word never passes
	assign ext_rdata = ext_rd ? (ext_addr ^ KEY) : ~last_ff;
endmodule : pmd_ext_mem

// ==== testbench/tb_top.sv ====
// Self-checking bench for the program memory mode decoder.
// Assumes the external memory model answers in the strobe cycle.
`timescale 1ns/1ps
module tb_top;
	localparam int ONC = 64;
	localparam logic [15:0] KEY = 16'h5A3C;
	typedef struct packed {logic flag; logic care; logic [15:0] word;} pmd_exp_s;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [1:0] cfg_mode = 2'h3;
	logic fetch_req = 1'b0, vec_req = 1'b0, pc_load = 1'b0, prog_req = 1'b0, prog_we = 1'b0;
	logic [1:0] vec_sel = 2'h0;
	logic [15:0] pc_target = 16'h0000, prog_addr = 16'h0000, prog_wdata = 16'h0000;
	logic fetch_ready, fetch_valid, fetch_src_ext, ext_rd, prog_ack, prog_denied, code_protect;
	logic [15:0] fetch_word, pc, ext_addr, ext_rdata, prog_rdata;
	logic [1:0] mode;
	pmd_pkg::pmd_dbus_s dbus_in = '0;
	pmd_pkg::pmd_dbus_s dbus_out;
	logic dbus_on = 1'b0, mcu, xt, prot, mpu;
	logic [15:0] tpc;
	logic [15:0] mem [ONC];
	logic [31:0] rs = 32'h00001120;
	int miscompares = 0, samples_checked = 0, cycles = 0;
	pmd_exp_s fq[$], pq[$], fe, pe;
	pmd_pkg::pmd_dbus_s dq[$], de;

	pmd_decoder #(.ONCHIP_WORDS(ONC)) i_pmd_decoder (.ref_clk, .rst_b, .cfg_mode, .fetch_req,
		.vec_req, .vec_sel, .pc_load, .pc_target, .fetch_ready, .fetch_valid, .fetch_src_ext,
		.fetch_word, .pc, .ext_rd, .ext_addr, .ext_rdata, .dbus_in, .dbus_out, .prog_req,
		.prog_we, .prog_addr, .prog_wdata, .prog_ack, .prog_denied, .prog_rdata, .mode,
		.code_protect);
	pmd_ext_mem #(.KEY(KEY)) i_pmd_ext_mem (.ref_clk, .ext_rd, .ext_addr, .ext_rdata);

	// Clock at 200 MHz
	always #2.5 ref_clk = ~ref_clk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	// Expected fetch answer; on-chip words are unknowable in protected mode
	function automatic pmd_exp_s fexp(input logic [15:0] a);
		if (mpu || (xt && a >= ONC)) return '{1'b1, 1'b1, a ^ KEY};
		if (a >= ONC) return '{1'b0, 1'b1, pmd_pkg::PMD_UNDEF_WORD};
		return '{1'b0, !prot, mem[a[5:0]]};
	endfunction : fexp

	task automatic chk(input logic [25:0] got, input logic [25:0] exp, input string msg);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t %s got %0h exp %0h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic final_report();
		// An answer still owed at the end is a lost fetch or programmer reply
		if (fq.size() != 0 || pq.size() != 0) begin
			miscompares++;
			$display("CHECK FAILED %0t answers still expected", $time);
		end
		$display("samples_checked %0d miscompares %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report

	// Straps are held one cycle past the capture edge, then turned round
	task automatic do_reset(input logic [1:0] m);
		dbus_on <= 1'b0;
		rst_b <= 1'b0;
		cfg_mode <= m;
		repeat (16) @(posedge ref_clk);
		dq.delete();
		rst_b <= 1'b1;
		mcu = m == pmd_pkg::PMD_MODE_MCU;
		xt = m == pmd_pkg::PMD_MODE_EXT;
		prot = m == pmd_pkg::PMD_MODE_PROT;
		mpu = m == pmd_pkg::PMD_MODE_MPU;
		tpc = 16'h0000;
		@(posedge ref_clk);
		@(negedge ref_clk);
		chk(fetch_ready, 1'b1, "ready");
		chk(mode, m, "mode");
		chk(pc, 16'h0000, "reset pc");
		@(posedge ref_clk);
		cfg_mode <= ~m;
		dbus_on <= 1'b1;
		@(negedge ref_clk);
		chk(code_protect, prot, "protect");
	endtask : do_reset

	task automatic idle();
		@(posedge ref_clk);
		fetch_req <= 1'b0;
		prog_req <= 1'b0;
		vec_req <= 1'b0;
		pc_load <= 1'b0;
	endtask : idle

	task automatic fetch(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			fetch_req <= 1'b1;
			fq.push_back(fexp(tpc));
			tpc++;
		end
		idle();
	endtask : fetch

	// Vector load is raised together with a jump to prove its priority
	task automatic go(input logic v, input logic [1:0] s, input logic [15:0] t);
		@(posedge ref_clk);
		vec_req <= v;
		pc_load <= 1'b1;
		vec_sel <= s;
		pc_target <= t;
		tpc = v ? {10'h000, 3'(s) + 3'h1, 3'h0} : t;
		idle();
		@(negedge ref_clk);
		chk(pc, tpc, "pc load");
	endtask : go

	task automatic prog1(input logic we, input logic [15:0] a, input logic [15:0] d, input logic den);
		@(posedge ref_clk);
		prog_req <= 1'b1;
		prog_we <= we;
		prog_addr <= a;
		prog_wdata <= d;
		pq.push_back('{den, !we, den ? 16'h0000 : (a < ONC ? mem[a[5:0]] : 16'hFFFF)});
		if (we && !den && a < ONC) mem[a[5:0]] = d;
	endtask : prog1

	// Data bus traffic runs beside every fetch
	always @(posedge ref_clk) begin
		rs = xs(rs);
		dbus_in <= dbus_on ? pmd_pkg::pmd_dbus_s'(rs[25:0]) : '0;
		if (dbus_on && rs[25]) dq.push_back(pmd_pkg::pmd_dbus_s'(rs[25:0]));
	end

	// Outputs are compared mid-cycle, where they have settled
	always @(negedge ref_clk) begin
		if (fetch_valid === 1'b1) begin
			fe = fq.size() ? fq.pop_front() : 'x;
			chk(fetch_src_ext, fe.flag, "fetch source");
			if (fe.care) chk(fetch_word, fe.word, "fetch word");
		end
		if (prog_ack === 1'b1 || prog_denied === 1'b1) begin
			pe = pq.size() ? pq.pop_front() : 'x;
			chk(prog_ack, 1'b1, "prog ack");
			chk(prog_denied, pe.flag, "prog verdict");
			if (pe.care) chk(prog_rdata, pe.word, "prog data");
		end
		if (dbus_out.req === 1'b1) begin
			de = dq.size() ? dq.pop_front() : 'x;
			chk(dbus_out, de, "data bus");
		end
		if (ext_rd === 1'b1) chk(xt || mpu, 1'b1, "external read");
	end

	// Hang guard
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles > 4000) begin
			miscompares++;
			final_report();
		end
	end

	initial begin
		repeat (16) @(posedge ref_clk);
		for (int i = 0; i < 4; i++) begin
			do_reset(i == 0 ? 2'h2 : i == 1 ? 2'h1 : i == 2 ? 2'h0 : 2'h3);
			for (int a = 0; a < ONC; a++) begin
				rs = xs(rs);
				prog1(1'b1, 16'(a), rs[15:0], !(mcu || xt));
			end
			prog1(1'b0, 16'h0005, 16'h0000, !(mcu || xt));
			prog1(1'b0, 16'(ONC), 16'h0000, 1'b1);
			prog1(1'b0, 16'hFE00, 16'h0000, 1'b0);
			prog1(1'b1, 16'hFE01, 16'h1234, prot);
			prog1(1'b0, 16'hFE10, 16'h0000, !(mcu || mpu));
			prog1(1'b0, 16'hFF60, 16'h0000, !mcu);
			idle();
			fetch(4);
			for (int s = 0; s < 4; s++) begin
				go(1'b1, 2'(s), 16'h0100);
				fetch(2);
			end
			go(1'b0, 2'h0, 16'(ONC - 2));
			fetch(4);
			go(1'b0, 2'h0, 16'hFFFE);
			fetch(3);
			repeat (4) @(posedge ref_clk);
		end
		final_report();
	end
endmodule : tb_top
